// >>> hdl/sric_pkg.sv
// Constants, state encoding and field layout of the supply regulator control core.
// Assumes a single 10 MHz clock and asynchronous active-high reset in the user.
//
// Operation
// R1 - Overcurrent past disable time: output off, flag.
// R2 - After shutdown, output stays off until re-enabled.
// R3 - Host waits two seconds between re-enable attempts.
// R4 - Converter clock is sixteen times tone frequency.
// R5 - Source select picks internal or external tone.
// R6 - Pin plus gate bit give four tone options.
// R7 - Stopped external clock parks tone at pin level.
// R8 - SDA fall/rise with SCL high: start/stop.
// R9 - Seven address bits, direction, then acknowledge.
// R10 - Write byte: six data, two select bits.
// R11 - Reads alternate register one, two; start with one.
// R12 - Start or stop resets transfer state machine.
// R13 - Host sends one byte per addressed write.
// R14 - Matching address acknowledged low on ninth clock.
// R15 - Each received write byte acknowledged low.
// R16 - Host releases SDA before acknowledge clock.
// R17 - Read: release after byte; host ack continues.
// R18 - Attention asserts on new fault or power-on.
// R19 - Attention released when read address acknowledged.
// R20 - Fault flags latch and raise attention; others not.
// R21 - Flags latched until read completes; zero means healthy.
// R22 - Ignore bus until logic supply valid; flag undervoltage.
// R23 - Select 0 external, 1 internal; gate 1 on.
// R24 - Control fields clear to zero at power-up.
// R25 - Enable bit switches output; re-enable clears disabled flag.
// R26 - Disable timer counts while overcurrent, fires at limit.
package sric_pkg;

  // ===========================================================================
  // Clock and timing.
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned OC_TIME_MS    = 48;
  localparam int unsigned OC_CYCLES_DEF = OC_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned CONV_HZ       = 352_000;
  localparam int unsigned TONE_RATIO    = 16;
  localparam int unsigned CONV_HALF     = CLK_HZ / (2 * CONV_HZ);
  localparam logic [4:0]  CONV_LAST     = 5'(CONV_HALF - 1);
  localparam logic [2:0]  TONE_HALF_LAST = 3'(TONE_RATIO / 2 - 1);

  // ===========================================================================
  // Synchroniser lanes of the pin inputs.
  localparam int SY_N    = 8;
  localparam int SY_SCL  = 0;
  localparam int SY_SDA  = 1;
  localparam int SY_EXTERNAL_MODULATION_INPUT = 2;
  localparam int SY_OC   = 3;
  localparam int SY_OT   = 4;
  localparam int SY_UV   = 5;
  localparam int SY_PB   = 6;
  localparam int SY_SUP  = 7;

  // ===========================================================================
  // Serial bus address, control register selects and byte layout.
  localparam logic [4:0] ADDR_HI   = 5'h02;
  localparam logic [1:0] REG_CTRL0 = 2'h0;
  localparam logic [1:0] REG_CTRL2 = 2'h2;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam int B_ENB   = 5;
  localparam int B_ODT   = 4;
  localparam int B_TONE_SOURCE_SELECT = 0;
  localparam int B_TONE_GATE_BIT = 1;

  // ===========================================================================
  // AXI4-Lite map and responses.
  localparam int          AXI_AW   = 4;
  localparam logic [3:0]  OFF_VIEW = 4'h0;
  localparam logic [3:0]  OFF_CFG  = 4'h4;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;

  // Transfer states of the serial slave.
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_DATA, ST_WR_ACK, ST_RD_DATA, ST_RD_ACK, ST_WAIT_STOP
  } sric_i2c_st_t;

endpackage : sric_pkg

// >>> hdl/sric_top.sv
// Serial control slave, overcurrent timer, tone generator and fault flags.
// Assumes open-drain wiring outside; every pin input is asynchronous to mclk.
module sric_top import sric_pkg::*; #(
  parameter int unsigned OC_CYCLES = OC_CYCLES_DEF,
  parameter int          OC_W      = 20
) (
  // Clock and reset.
  input  wire logic              mclk,
  input  wire logic              reset,
  // Serial bus pins, SDA open drain.
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe,
  // Attention request, open drain, active low on the wire.
  output logic                   irq_o,
  output logic                   irq_oe,
  // Analog condition inputs and tone pin.
  input  wire logic              external_modulation_input,
  input  wire logic              overcurrent_cond,
  input  wire logic              overtemp_cond,
  input  wire logic              undervoltage_cond,
  input  wire logic              power_bad_cond,
  input  wire logic              internal_logic_supply_ok,
  // Regulator controls.
  output logic                   antenna_supply_output,
  output logic [3:0]             voltage_select,
  output logic                   converter_clk,
  output logic                   tone_out,
  output logic                   tone_active,
  // AXI4-Lite write channels.
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // AXI4-Lite read channels.
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp
);

  // ===========================================================================
  // Parameter checks.
  if (OC_CYCLES < 2 || OC_CYCLES >= (64'd1 << OC_W)) begin : g_bad_oc
    $error("OC_CYCLES does not fit the disable timer width");
  end

  localparam logic [OC_W-1:0] OC_LAST = OC_W'(OC_CYCLES - 1);

  // ===========================================================================
  // State of the block.
  typedef struct packed {
    logic [SY_N-1:0] sy1;
    logic [SY_N-1:0] sy2;
    logic            scl_p;
    logic            sda_p;
    logic            sup_p;
    sric_i2c_st_t    st;
    logic [3:0]      bitc;
    logic [7:0]      sh;
    logic            rw;
    logic            rsel;
    logic            rack;
    logic            rdone;
    logic            sda_oe;
    logic            irq;
    logic [3:0]      vsel;
    logic            overcurrent_disable_timer;
    logic            output_enable_bit;
    logic            tone_source_select;
    logic            tone_gate_bit;
    logic            overtemperature_flag;
    logic            undervoltage_flag;
    logic            overcurrent_flag;
    logic            dis;
    logic            power_not_good_flag;
    logic [OC_W-1:0] occ;
    logic [4:0]      convc;
    logic            conv;
    logic [2:0]      tdiv;
    logic            itone;
    logic            tone_out;
    logic            tone_on;
    logic [1:0]      asel;
    logic            awready;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arready;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
  } sric_state_t;

  sric_state_t s_q;
  sric_state_t s_d;

  // Decoded views of the synchronised inputs.
  logic       scl;
  logic       sda;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       sup;
  logic       ocond;
  logic [7:0] stat1;
  logic [7:0] stat2;
  logic [7:0] next_byte;
  logic       conv_rise;
  logic       oc_fire;
  logic       clr_flags;
  logic       irq_rel;
  logic       flag_event;

  // Bus conditions are taken from the second synchroniser stage only.
  assign scl       = s_q.sy2[SY_SCL];
  assign sda       = s_q.sy2[SY_SDA];
  assign sup       = s_q.sy2[SY_SUP];
  assign ocond     = s_q.sy2[SY_OC];
  assign scl_rise  = scl & ~s_q.scl_p;
  assign scl_fall  = ~scl & s_q.scl_p;
  assign start_det = scl & s_q.scl_p & s_q.sda_p & ~sda; // R8
  assign stop_det  = scl & s_q.scl_p & ~s_q.sda_p & sda; // R8

  // Status bytes; all zero means the output is on and healthy.
  assign stat1     = {5'h00, s_q.power_not_good_flag, s_q.overcurrent_flag, s_q.dis}; // R21
  assign stat2     = {6'h00, s_q.overtemperature_flag, s_q.undervoltage_flag};
  assign next_byte = s_q.rsel ? stat2 : stat1; // R11

  // Converter edge and disable timer expiry.
  assign conv_rise = (s_q.convc == CONV_LAST) & ~s_q.conv;
  assign oc_fire   = s_q.output_enable_bit & ocond & (s_q.occ == OC_LAST); // R1 R26

  // ===========================================================================
  // Next-state logic.
  always_comb begin
    s_d        = s_q;
    clr_flags  = 1'b0;
    irq_rel    = 1'b0;
    flag_event = 1'b0;
    s_d.sy1    = {internal_logic_supply_ok, power_bad_cond, undervoltage_cond, overtemp_cond,
                  overcurrent_cond, external_modulation_input, sda_i, scl_i};
    s_d.sy2    = s_q.sy1;
    s_d.scl_p  = scl;
    s_d.sda_p  = sda;
    s_d.sup_p  = sup;

    // Serial slave; nothing is answered before the logic supply is valid.
    if (!sup) begin
      s_d.st     = ST_IDLE; // R22
      s_d.sda_oe = 1'b0;
    end else if (start_det || stop_det) begin
      s_d.st     = start_det ? ST_ADDR : ST_IDLE; // R12
      s_d.bitc   = 4'h0;
      s_d.sda_oe = 1'b0;
      s_d.rsel   = 1'b0; // R11
      if (s_q.rdone) begin
        clr_flags = 1'b1; // R21
        s_d.rdone = 1'b0;
      end
    end else begin
      case (s_q.st)
        ST_ADDR: begin
          if (scl_rise) begin
            s_d.sh   = {s_q.sh[6:0], sda}; // R9
            s_d.bitc = s_q.bitc + 4'h1;
          end else if (scl_fall && s_q.bitc == BITS_BYTE) begin
            if (s_q.sh[7:1] == {ADDR_HI, s_q.asel}) begin
              s_d.st     = ST_ADDR_ACK;
              s_d.sda_oe = 1'b1; // R14
              s_d.rw     = s_q.sh[0];
            end else begin
              s_d.st = ST_WAIT_STOP;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_rise && s_q.rw) begin
            irq_rel  = 1'b1; // R19
            s_d.sh   = stat1; // R11
            s_d.rsel = 1'b1;
          end else if (scl_fall) begin
            s_d.bitc   = 4'h0;
            s_d.st     = s_q.rw ? ST_RD_DATA : ST_WR_DATA;
            s_d.sda_oe = s_q.rw & ~s_q.sh[7];
          end
        end
        ST_WR_DATA: begin
          if (scl_rise) begin
            s_d.sh   = {s_q.sh[6:0], sda};
            s_d.bitc = s_q.bitc + 4'h1;
          end else if (scl_fall && s_q.bitc == BITS_BYTE) begin
            s_d.st     = ST_WR_ACK;
            s_d.sda_oe = 1'b1; // R15
            if (s_q.sh[7:6] == REG_CTRL0) begin
              s_d.vsel = s_q.sh[3:0]; // R10
              s_d.overcurrent_disable_timer  = s_q.sh[B_ODT];
              s_d.output_enable_bit  = s_q.sh[B_ENB]; // R25
            end else if (s_q.sh[7:6] == REG_CTRL2) begin
              s_d.tone_source_select = s_q.sh[B_TONE_SOURCE_SELECT]; // R10
              s_d.tone_gate_bit = s_q.sh[B_TONE_GATE_BIT];
            end
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            s_d.sda_oe = 1'b0;
            s_d.st     = ST_WAIT_STOP; // R13
          end
        end
        ST_RD_DATA: begin
          if (scl_fall) begin
            s_d.bitc = s_q.bitc + 4'h1;
            if (s_q.bitc == BITS_BYTE - 4'h1) begin
              s_d.sda_oe = 1'b0; // R17
              s_d.st     = ST_RD_ACK;
              s_d.rdone  = 1'b1;
            end else begin
              s_d.sh     = {s_q.sh[6:0], 1'b0};
              s_d.sda_oe = ~s_q.sh[6];
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            s_d.rack = ~sda; // R17
          end else if (scl_fall) begin
            if (s_q.rack) begin
              s_d.sh     = next_byte; // R11
              s_d.rsel   = ~s_q.rsel;
              s_d.sda_oe = ~next_byte[7];
              s_d.bitc   = 4'h0;
              s_d.st     = ST_RD_DATA;
            end else begin
              s_d.st = ST_WAIT_STOP; // R17
            end
          end
        end
        ST_IDLE, ST_WAIT_STOP: begin
          s_d.sda_oe = 1'b0;
        end
        default: begin
          s_d.st     = ST_IDLE;
          s_d.sda_oe = 1'b0;
        end
      endcase
    end

    // Disable timer; expiry overrides a same-cycle enable write.
    s_d.occ = (s_q.output_enable_bit & ocond) ? s_q.occ + OC_W'(1) : '0; // R26
    if (oc_fire) begin
      s_d.output_enable_bit = 1'b0; // R1 R2
      s_d.occ = '0;
    end
    s_d.dis = ~s_d.output_enable_bit; // R25

    // Fault flags: a new condition wins over a read clear.
    flag_event = oc_fire | (s_q.sy2[SY_OT] & ~s_q.overtemperature_flag) | (s_q.sy2[SY_UV] & ~s_q.undervoltage_flag)
               | (sup & ~s_q.sup_p); // R18 R20
    s_d.overcurrent_flag = (s_q.overcurrent_flag & ~(clr_flags & ~ocond)) | oc_fire; // R1 R21
    s_d.overtemperature_flag = (s_q.overtemperature_flag & ~(clr_flags & ~s_q.sy2[SY_OT])) | s_q.sy2[SY_OT]; // R20
    s_d.undervoltage_flag = (s_q.undervoltage_flag & ~(clr_flags & ~s_q.sy2[SY_UV])) | s_q.sy2[SY_UV] | ~sup; // R22
    s_d.power_not_good_flag = s_q.sy2[SY_PB]; // R20
    s_d.irq = flag_event | (s_q.irq & ~irq_rel); // R18 R19

    // Converter clock and internal tone from one divider chain.
    s_d.convc = (s_q.convc == CONV_LAST) ? 5'h00 : s_q.convc + 5'h01;
    if (s_q.convc == CONV_LAST) begin
      s_d.conv = ~s_q.conv;
    end
    if (conv_rise) begin
      s_d.tdiv = s_q.tdiv + 3'h1; // R4
      if (s_q.tdiv == TONE_HALF_LAST) begin
        s_d.itone = ~s_q.itone; // R4
      end
    end

    // Tone option from source select, gate bit and the modulation pin.
    if (s_q.tone_source_select) begin
      s_d.tone_on  = s_q.tone_gate_bit; // R5 R23
      s_d.tone_out = s_q.tone_gate_bit & s_q.itone;
    end else if (!s_q.tone_gate_bit) begin
      s_d.tone_on  = s_q.sy2[SY_EXTERNAL_MODULATION_INPUT]; // R6
      s_d.tone_out = s_q.sy2[SY_EXTERNAL_MODULATION_INPUT] & s_q.itone;
    end else begin
      s_d.tone_on  = 1'b1; // R6
      s_d.tone_out = s_q.sy2[SY_EXTERNAL_MODULATION_INPUT]; // R7
    end

    // AXI4-Lite write: address and data are taken together.
    s_d.awready = s_axi_awvalid & s_axi_wvalid & ~s_q.bvalid & ~s_q.awready;
    if (s_axi_awvalid && s_axi_wvalid && s_q.awready) begin
      s_d.bvalid = 1'b1;
      s_d.bresp  = RESP_OK;
      if (s_axi_awaddr == OFF_CFG) begin
        if (s_axi_wstrb[0]) begin
          s_d.asel = s_axi_wdata[1:0];
        end
      end else if (s_axi_awaddr != OFF_VIEW) begin
        s_d.bresp = RESP_ERR;
      end
    end else if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // AXI4-Lite read of the block view and the configuration.
    s_d.arready = s_axi_arvalid & ~s_q.rvalid & ~s_q.arready;
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OK;
      case (s_axi_araddr)
        OFF_VIEW: s_d.rdata = {17'h0_0000, s_q.irq, s_q.power_not_good_flag, s_q.dis, s_q.overcurrent_flag, s_q.undervoltage_flag,
                               s_q.overtemperature_flag, s_q.tone_on, s_q.tone_gate_bit, s_q.tone_source_select, s_q.output_enable_bit,
                               s_q.overcurrent_disable_timer, s_q.vsel};
        OFF_CFG:  s_d.rdata = {30'h0000_0000, s_q.asel};
        default: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = RESP_ERR;
        end
      endcase
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  // ===========================================================================
  // State register; control fields clear, disabled and undervoltage set.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_q     <= '0; // R24
      s_q.dis <= 1'b1;
      s_q.undervoltage_flag <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ===========================================================================
  // Outputs straight from the state register; sda_o and irq_o are tied low.
  assign sda_o                 = 1'b0;
  assign sda_oe                = s_q.sda_oe;
  assign irq_o                 = 1'b0;
  assign irq_oe                = s_q.irq;
  assign antenna_supply_output = s_q.output_enable_bit;
  assign voltage_select        = s_q.vsel;
  assign converter_clk         = s_q.conv;
  assign tone_out              = s_q.tone_out;
  assign tone_active           = s_q.tone_on;
  assign s_axi_awready         = s_q.awready;
  assign s_axi_wready          = s_q.awready;
  assign s_axi_bvalid          = s_q.bvalid;
  assign s_axi_bresp           = s_q.bresp;
  assign s_axi_arready         = s_q.arready;
  assign s_axi_rvalid          = s_q.rvalid;
  assign s_axi_rdata           = s_q.rdata;
  assign s_axi_rresp           = s_q.rresp;

  // ===========================================================================
  // Assertions and covers.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_oc_shutdown: assert property (oc_fire |=> !s_q.output_enable_bit && s_q.overcurrent_flag) // R1
    else $error("overcurrent expiry did not shut the output off");
  a_no_restart: assert property ((!s_q.output_enable_bit && !(s_q.st == ST_WR_DATA && scl_fall))
                                 |=> !s_q.output_enable_bit) // R2
    else $error("output restarted without a control write");
  a_tone_ratio: assert property ($changed(s_q.itone) |-> $past(conv_rise)
                                 && $past(s_q.tdiv) == TONE_HALF_LAST) // R4
    else $error("tone toggled off the converter divider");
  a_tone_internal: assert property (s_q.tone_source_select && s_q.tone_gate_bit
                                    |=> s_q.tone_on && s_q.tone_out == $past(s_q.itone)) // R5
    else $error("internal tone not routed to the output");
  a_tone_park: assert property (!s_q.tone_source_select && s_q.tone_gate_bit
                                |=> s_q.tone_out == $past(s_q.sy2[SY_EXTERNAL_MODULATION_INPUT])) // R7
    else $error("clocked tone does not follow the modulation pin");
  a_start_reset: assert property (sup && start_det |=> s_q.st == ST_ADDR && !s_q.sda_oe) // R12
    else $error("start did not restart the transfer");
  a_stop_reset: assert property (sup && stop_det |=> s_q.st == ST_IDLE) // R8
    else $error("stop did not end the transfer");
  a_addr_ack: assert property (s_q.st == ST_ADDR && sup && !start_det && !stop_det && scl_fall
                               && s_q.bitc == BITS_BYTE && s_q.sh[7:1] == {ADDR_HI, s_q.asel}
                               |=> s_q.sda_oe [*1] ##1 1) // R14
    else $error("matching address not acknowledged");
  a_irq_release: assert property (irq_rel && !flag_event |=> !s_q.irq) // R19
    else $error("attention request not released by read address");
  a_irq_on_fault: assert property (oc_fire |=> s_q.irq ##1 s_q.irq || irq_rel) // R18
    else $error("fault did not raise the attention request");
  a_unpowered: assert property (!sup |=> s_q.st == ST_IDLE && s_q.undervoltage_flag) // R22
    else $error("bus answered before logic supply was valid");
  a_axi_write: assert property (s_axi_awvalid && s_axi_wvalid && s_q.awready |=> s_q.bvalid)
    else $error("write response missing");

  c_read_done:  cover property (s_q.st == ST_RD_ACK ##[1:200] stop_det);
  c_write_done: cover property (s_q.st == ST_WR_ACK ##[1:200] stop_det);
  c_shutdown:   cover property (oc_fire);
  c_irq_clear:  cover property (s_q.irq ##1 !s_q.irq);

endmodule : sric_top

// >>> dv/sric_i2c_master.sv
// Serial bus master model that stands opposite the control core.
// Assumes the bench resolves the open-drain SDA wire with a pull-up.
module sric_i2c_master (
  // Clock and bus.
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // The bus starts idle, both lines released.
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // Each phase lasts 8 mclk cycles, well above the synchroniser delay.
  task automatic half();
    repeat (8) @(posedge mclk);
  endtask : half

  // A start pulls SDA low while SCL is high.
  task automatic start();
    sda_low <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b1;
    half();
    scl <= 1'b0;
    half();
  endtask : start

  // A stop releases SDA while SCL is high.
  task automatic stop();
    sda_low <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b0;
    half();
  endtask : stop

  // Data changes only while SCL is low and is sampled late in the high phase.
  task automatic bit_io(input logic b, output logic s);
    sda_low <= !b;
    half();
    scl <= 1'b1;
    half();
    s = sda;
    scl <= 1'b0;
    half();
  endtask : bit_io

  // A byte goes out MSB first; SDA is released so the slave can acknowledge.
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask : send

  // A byte comes in; a low acknowledge asks for more, a release ends the read.
  task automatic recv(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!more, s);
  endtask : recv
endmodule : sric_i2c_master

// >>> dv/tb.sv
// Self-checking bench of the supply regulator control core.
// Assumes the master model drives the bus and SDA is pulled up here.
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Signals. The overcurrent time is shortened to OC cycles.
  localparam int         OC = 50;
  localparam logic [6:0] A0 = 7'h08;
  localparam logic [6:0] A1 = 7'h09;
  logic        mclk = 1'b0, reset = 1'b1, sup = 1'b0, oc = 1'b0, ext = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [3:0]  awa = 4'h0, ara = 4'h0, vsel;
  logic [31:0] wd = 32'h0000_0000, rdat;
  logic        scl, m_low, sda_o, sda_oe, irq_o, irq_oe, ant, conv, tone, tact;
  logic        awr, wrdy, bv, arr, rv;
  logic [1:0]  bresp, rresp;
  int          miscompares = 0, samples_checked = 0, cyc = 0;
  wire         sda = !(sda_oe | m_low);

  // Clock and a watchdog that cuts a hang short.
  always #50 mclk = !mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      print_verdict();
    end
  end

  sric_top #(.OC_CYCLES(OC)) i_sric_top (
    .mclk(mclk), .reset(reset), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .irq_o(irq_o), .irq_oe(irq_oe),
    .external_modulation_input(ext), .overcurrent_cond(oc), .overtemp_cond(1'b0),
    .undervoltage_cond(1'b0), .power_bad_cond(1'b0), .internal_logic_supply_ok(sup),
    .antenna_supply_output(ant), .voltage_select(vsel), .converter_clk(conv),
    .tone_out(tone), .tone_active(tact), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .s_axi_rdata(rdat), .s_axi_rresp(rresp));
  sric_i2c_master i_sric_i2c_master (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(m_low));

  // ==========================================================================
  // Shared tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // Register bus write; each channel is released once taken.
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge mclk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wrdy === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1);
    r = bresp;
    bre <= 1'b0;
  endtask : axi_wr

  // Register bus read.
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge mclk);
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rdat;
    r = rresp;
    rre <= 1'b0;
  endtask : axi_rd

  // One addressed write of a single byte, then stop.
  task automatic i2c_wr(input logic [6:0] a, input logic [7:0] b, output logic [1:0] k);
    i_sric_i2c_master.start();
    i_sric_i2c_master.send({a, 1'b0}, k[1]);
    i_sric_i2c_master.send(b, k[0]);
    i_sric_i2c_master.stop();
  endtask : i2c_wr

  // Read of three status bytes; the master refuses after the third.
  task automatic i2c_rd(input logic [6:0] a, output logic k, output logic [23:0] d);
    i_sric_i2c_master.start();
    i_sric_i2c_master.send({a, 1'b1}, k);
    i_sric_i2c_master.recv(1'b1, d[23:16]);
    i_sric_i2c_master.recv(1'b1, d[15:8]);
    i_sric_i2c_master.recv(1'b0, d[7:0]);
    i_sric_i2c_master.stop();
  endtask : i2c_rd

  // Counts one half period of the converter clock (t 0) or the tone (t 1).
  task automatic hl(input logic t, output int n);
    logic v;
    v = t ? tone : conv;
    while ((t ? tone : conv) === v) @(posedge mclk);
    v = t ? tone : conv;
    n = 0;
    while ((t ? tone : conv) === v) begin
      @(posedge mclk);
      n++;
    end
  endtask : hl

  // ==========================================================================
  // Scenarios.
  task automatic t_power_axi();
    logic [1:0]  k;
    logic [31:0] d;
    i2c_wr(A0, 8'h35, k);
    chk(k, 2'b00);
    chk(irq_oe, 0);
    axi_rd(4'h0, d, k);
    chk(d, 32'h0000_1400);
    sup <= 1'b1;
    repeat (10) @(posedge mclk);
    chk(irq_oe, 1);
    axi_wr(4'h4, 32'h0000_0001, k);
    chk(k, sric_pkg::RESP_OK);
    axi_rd(4'h4, d, k);
    chk(d, 32'h0000_0001);
    axi_wr(4'h8, 32'h0000_0001, k);
    chk(k, sric_pkg::RESP_ERR);
    axi_rd(4'hC, d, k);
    chk(k, sric_pkg::RESP_ERR);
  endtask : t_power_axi

  task automatic t_read();
    logic        k;
    logic [23:0] d;
    i2c_rd(A0, k, d);
    chk(k, 0);
    chk(irq_oe, 1);
    i_sric_i2c_master.start();
    i_sric_i2c_master.send({A1, 1'b0}, k);
    i2c_rd(A1, k, d);
    chk(k, 1);
    chk(irq_oe, 0);
    chk(d, 24'h01_0101);
    i2c_rd(A1, k, d);
    chk(d, 24'h01_0001);
  endtask : t_read

  task automatic t_write();
    logic [1:0]  k;
    logic        a;
    logic [23:0] d;
    int          n;
    i2c_wr(A1, 8'h35, k);
    chk(k, 2'b11);
    chk({ant, vsel}, 5'h15);
    i2c_wr(A1, 8'h4A, k);
    chk(vsel, 4'h5);
    i2c_rd(A1, a, d);
    chk(d[23:16], 8'h00);
    i2c_wr(A1, 8'h83, k);
    chk(tact, 1);
    hl(1'b0, n);
    chk(n, 14);
    hl(1'b1, n);
    chk(n, 224);
    i2c_wr(A1, 8'h81, k);
    chk(tact, 0);
    i2c_wr(A1, 8'h82, k);
    ext <= 1'b1;
    repeat (8) @(posedge mclk);
    chk(tone, 1);
    ext <= 1'b0;
    repeat (8) @(posedge mclk);
    chk(tone, 0);
    i2c_wr(A1, 8'h15, k);
    chk({ant, irq_oe}, 2'b00);
  endtask : t_write

  task automatic t_oc();
    logic [1:0]  k;
    logic        a;
    logic [23:0] d;
    i2c_wr(A1, 8'h35, k);
    oc <= 1'b1;
    repeat (OC - 10) @(posedge mclk);
    chk(ant, 1);
    repeat (20) @(posedge mclk);
    chk({ant, irq_oe}, 2'b01);
    oc <= 1'b0;
    repeat (100) @(posedge mclk);
    chk(ant, 0);
    i2c_rd(A1, a, d);
    chk(d, 24'h03_0003);
    i2c_rd(A1, a, d);
    chk(d[23:16], 8'h01);
    i2c_wr(A1, 8'h35, k);
    chk(ant, 1);
  endtask : t_oc

  // Main sequence: reset for 16 cycles, then the scenarios.
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    t_power_axi();
    t_read();
    t_write();
    t_oc();
    print_verdict();
  end
endmodule : tb
